//--- design/usbhmc_top.v
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/1ns
`include "usbhmc_consts.vh"

module usbhmc_top #(
	parameter SOF_DELAY_CYC = `USBHMC_SOF_DELAY_CYC,
	parameter FRAME_CYC = `USBHMC_FRAME_CYC
) (
	input wire clock,
	input wire reset,
	input wire soft_reset,
	input wire resume_pin,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	output reg irq,
	output reg wakeup,
	output reg port_reset,
	output reg sof_pulse,
	output reg ctrl_active,
	output reg bulk_active,
	output reg periodic_active,
	output reg iso_active,
	output reg [1:0] control_bulk_ratio
);
	localparam ST_IDLE = 2'b01;
	localparam ST_DONE = 2'b10;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg [1:0] bus_st_ff;
	reg [1:0] ratio_ff;
	reg ple_ff;
	reg ie_ff;
	reg cle_ff;
	reg ble_ff;
	reg [1:0] fs_ff;
	reg ir_ff;
	reg rwc_ff;
	reg rwe_ff;
	reg [`USBHMC_STAT_W-1:0] stat_ff;
	reg [`USBHMC_STAT_W-1:0] mask_ff;
	reg [1:0] fs_prev_ff;
	reg sof_run_ff;
	reg frame_run_ff;
	reg resume_prev_ff;
	reg [31:0] nxt_prdata;
	wire resume_sync;
	wire delay_done;
	wire frame_done;
	wire acc;
	wire wr;
	wire wr_ctrl;
	wire frame_tick;
	wire resume_evt;
	wire enter_oper;
	wire [`USBHMC_STAT_W-1:0] set_bits;

	assign acc = psel && penable && bus_st_ff == ST_IDLE;
	assign wr = acc && pwrite;
	assign wr_ctrl = wr && paddr == `USBHMC_OFF_CTRL;
	assign enter_oper = fs_ff == `USBHMC_FS_OPER && fs_prev_ff != `USBHMC_FS_OPER;
	assign frame_tick = (delay_done || frame_done) && fs_ff == `USBHMC_FS_OPER;
	assign resume_evt = resume_sync && !resume_prev_ff;
	assign set_bits = {resume_evt, frame_tick, 2'b00};

	// ----------------------------------------
	// Pin sync and counters
	// ----------------------------------------
	usbhmc_sync u_sync (
		.clock(clock),
		.reset(reset),
		.din(resume_pin),
		.dout(resume_sync)
	);

	usbhmc_counter #(.W(24)) u_delay (
		.clock(clock),
		.reset(reset),
		.load(enter_oper),
		.load_val(SOF_DELAY_CYC[23:0]),
		.run(fs_ff == `USBHMC_FS_OPER),
		.done(delay_done)
	);

	usbhmc_counter #(.W(24)) u_frame (
		.clock(clock),
		.reset(reset),
		.load(frame_tick),
		.load_val(FRAME_CYC[23:0]),
		.run(fs_ff == `USBHMC_FS_OPER),
		.done(frame_done)
	);

	// ----------------------------------------
	// APB slave, one wait state
	// ----------------------------------------
	always @* begin
		nxt_prdata = 32'h00000000;
		case (paddr)
			`USBHMC_OFF_CTRL: begin
				nxt_prdata = {21'h000000, rwe_ff, rwc_ff, ir_ff, fs_ff, ble_ff, cle_ff,
					ie_ff, ple_ff, ratio_ff};
			end
			`USBHMC_OFF_INTSTAT: begin
				nxt_prdata = {28'h0000000, stat_ff};
			end
			`USBHMC_OFF_INTMASK: begin
				nxt_prdata = {28'h0000000, mask_ff};
			end
			default: begin
				nxt_prdata = 32'h00000000;
			end
		endcase
	end

	always @(posedge clock) begin
		if (reset) begin
			bus_st_ff <= ST_IDLE;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			case (bus_st_ff)
				ST_IDLE: begin
					pready <= acc;
					pslverr <= acc && paddr != `USBHMC_OFF_CTRL &&
						paddr != `USBHMC_OFF_INTSTAT && paddr != `USBHMC_OFF_INTMASK;
					if (acc) begin
						bus_st_ff <= ST_DONE;
						prdata <= pwrite ? 32'h00000000 : nxt_prdata;
					end
				end
				ST_DONE: begin
					pready <= 1'b0;
					pslverr <= 1'b0;
					bus_st_ff <= ST_IDLE;
				end
				default: begin
					bus_st_ff <= ST_IDLE;
					pready <= 1'b0;
					pslverr <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Mode control register
	// ----------------------------------------
	always @(posedge clock) begin
		if (reset) begin
			ratio_ff <= 2'h0;
			ple_ff <= 1'b0;
			ie_ff <= 1'b0;
			cle_ff <= 1'b0;
			ble_ff <= 1'b0;
			fs_ff <= `USBHMC_FS_RESET;
			ir_ff <= 1'b0;
			rwc_ff <= 1'b0;
			rwe_ff <= 1'b0;
		end else if (soft_reset) begin
			ratio_ff <= 2'h0;
			ple_ff <= 1'b0;
			ie_ff <= 1'b0;
			cle_ff <= 1'b0;
			ble_ff <= 1'b0;
			fs_ff <= `USBHMC_FS_SUSPEND;
			ir_ff <= 1'b0;
			rwe_ff <= 1'b0;
		end else if (wr_ctrl) begin
			ratio_ff <= pwdata[`USBHMC_RATIO_LO+1:`USBHMC_RATIO_LO];
			ple_ff <= pwdata[`USBHMC_PLE_BIT];
			ie_ff <= pwdata[`USBHMC_IE_BIT];
			cle_ff <= pwdata[`USBHMC_CLE_BIT];
			ble_ff <= pwdata[`USBHMC_BLE_BIT];
			fs_ff <= pwdata[`USBHMC_FS_LO+1:`USBHMC_FS_LO];
			ir_ff <= pwdata[`USBHMC_IR_BIT];
			rwc_ff <= pwdata[`USBHMC_RWC_BIT];
			rwe_ff <= pwdata[`USBHMC_RWE_BIT];
		end else if (fs_ff == `USBHMC_FS_SUSPEND && resume_evt) begin
			fs_ff <= `USBHMC_FS_RESUME;
		end
	end

	// ----------------------------------------
	// Status, mask, interrupt and wakeup
	// ----------------------------------------
	always @(posedge clock) begin
		if (reset) begin
			stat_ff <= 4'h0;
			mask_ff <= 4'h0;
			fs_prev_ff <= `USBHMC_FS_RESET;
			resume_prev_ff <= 1'b0;
			irq <= 1'b0;
			wakeup <= 1'b0;
		end else begin
			fs_prev_ff <= fs_ff;
			resume_prev_ff <= resume_sync;
			if (wr && paddr == `USBHMC_OFF_INTMASK) begin
				mask_ff <= pwdata[`USBHMC_STAT_W-1:0];
			end
			if (wr && paddr == `USBHMC_OFF_INTSTAT) begin
				stat_ff <= (stat_ff & ~pwdata[`USBHMC_STAT_W-1:0]) | set_bits;
			end else begin
				stat_ff <= stat_ff | set_bits;
			end
			irq <= |(stat_ff & mask_ff);
			wakeup <= rwe_ff && stat_ff[`USBHMC_RD_BIT];
		end
	end

	// ----------------------------------------
	// Frame scheduling outputs
	// ----------------------------------------
	always @(posedge clock) begin
		if (reset) begin
			sof_run_ff <= 1'b0;
			frame_run_ff <= 1'b0;
			sof_pulse <= 1'b0;
			ctrl_active <= 1'b0;
			bulk_active <= 1'b0;
			periodic_active <= 1'b0;
			iso_active <= 1'b0;
			control_bulk_ratio <= 2'h0;
			port_reset <= 1'b1;
		end else begin
			sof_pulse <= frame_tick;
			sof_run_ff <= fs_ff == `USBHMC_FS_OPER;
			frame_run_ff <= sof_run_ff;
			port_reset <= fs_ff == `USBHMC_FS_RESET;
			control_bulk_ratio <= ratio_ff;
			if (fs_ff != `USBHMC_FS_OPER) begin
				ctrl_active <= 1'b0;
				bulk_active <= 1'b0;
				periodic_active <= 1'b0;
				iso_active <= 1'b0;
			end else if (frame_tick) begin
				ctrl_active <= cle_ff;
				bulk_active <= ble_ff;
				periodic_active <= ple_ff;
				iso_active <= ple_ff && ie_ff;
			end
		end
	end
endmodule

//--- design/usbhmc_consts.vh
`ifndef USBHMC_CONSTS_VH
`define USBHMC_CONSTS_VH
// Functional notes
// - Only driver writes, except state and capability
// - Wakeup when enable and resume-detected set
// - Wakeup enable never gates the interrupt
// - Hard reset clears capability; soft keeps it
// - State 00 reset, 01 resume
// - Frame starts begin 1 ms after operational; on re-entry a frame count held from before can start one sooner
// - Frame start flag set per frame
// - Only suspend to resume on its own
// - Hard reset enters reset state, resets ports
// - Any written state accepted unchecked
// - Control enable starts processing next frame
// - Control clear stops after next frame start
// - Control enable sampled at each decision

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define USBHMC_OFF_CTRL 12'h004
`define USBHMC_OFF_INTSTAT 12'h00c
`define USBHMC_OFF_INTMASK 12'h010
`define USBHMC_OFF_CMD 12'h008

// ----------------------------------------
// Control fields
// ----------------------------------------
`define USBHMC_RATIO_LO 0
`define USBHMC_PLE_BIT 2
`define USBHMC_IE_BIT 3
`define USBHMC_CLE_BIT 4
`define USBHMC_BLE_BIT 5
`define USBHMC_FS_LO 6
`define USBHMC_IR_BIT 8
`define USBHMC_RWC_BIT 9
`define USBHMC_RWE_BIT 10
`define USBHMC_CTRL_MASK 32'h000007ff
`define USBHMC_CTRL_RESET 11'h000

// ----------------------------------------
// Functional states
// ----------------------------------------
`define USBHMC_FS_RESET 2'h0
`define USBHMC_FS_RESUME 2'h1
`define USBHMC_FS_OPER 2'h2
`define USBHMC_FS_SUSPEND 2'h3

// ----------------------------------------
// Status bits
// ----------------------------------------
`define USBHMC_SF_BIT 2
`define USBHMC_RD_BIT 3
`define USBHMC_STAT_W 4

// ----------------------------------------
// Timing
// ----------------------------------------
`define USBHMC_CLK_MHZ 20
`define USBHMC_SOF_DELAY_US 1000
`define USBHMC_FRAME_US 1000
`define USBHMC_SOF_DELAY_CYC (`USBHMC_SOF_DELAY_US * `USBHMC_CLK_MHZ)
`define USBHMC_FRAME_CYC (`USBHMC_FRAME_US * `USBHMC_CLK_MHZ)
`endif

//--- design/usbhmc_sync.v
`timescale 1ns/1ns
`include "usbhmc_consts.vh"

// ----------------------------------------
// Three-stage synchroniser with agreement
// ----------------------------------------
module usbhmc_sync (
	input wire clock,
	input wire reset,
	input wire din,
	output reg dout
);
	reg s1_ff;
	reg s2_ff;
	reg s3_ff;

	always @(posedge clock) begin
		if (reset) begin
			s1_ff <= 1'b0;
			s2_ff <= 1'b0;
			s3_ff <= 1'b0;
			dout <= 1'b0;
		end else begin
			s1_ff <= din;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			if (s2_ff == s3_ff) begin
				dout <= s3_ff;
			end
		end
	end
endmodule

//--- design/usbhmc_counter.v
`timescale 1ns/1ns
`include "usbhmc_consts.vh"

// ----------------------------------------
// Down counter with terminal pulse
// ----------------------------------------
module usbhmc_counter #(
	parameter W = 24
) (
	input wire clock,
	input wire reset,
	input wire load,
	input wire [W-1:0] load_val,
	input wire run,
	output reg done
);
	reg [W-1:0] cnt_ff;

	always @(posedge clock) begin
		if (reset) begin
			cnt_ff <= {W{1'b0}};
			done <= 1'b0;
		end else if (load) begin
			cnt_ff <= load_val;
			done <= 1'b0;
		end else if (run && cnt_ff != {W{1'b0}}) begin
			cnt_ff <= cnt_ff - {{(W-1){1'b0}}, 1'b1};
			done <= (cnt_ff == {{(W-1){1'b0}}, 1'b1});
		end else begin
			done <= 1'b0;
		end
	end
endmodule

//--- verif/usbhmc_dev.sv
`timescale 1ns/1ns
// ----------------------------------------
// Downstream device resume source
// ----------------------------------------
module usbhmc_dev #(
	parameter HOLD = 6
) (
	input wire clock,
	input wire wake_req,
	output logic resume_pin
);
	int cnt = 0;
	always @(posedge clock) begin
		if (wake_req)
			cnt <= HOLD;
		else if (cnt != 0)
			cnt <= cnt - 1;
	end
	// Released line idles low
	assign resume_pin = (cnt != 0);
endmodule

//--- verif/usbhmc_checker.sv
`timescale 1ns/1ns
// ----------------------------------------
// Port checker
// ----------------------------------------
module usbhmc_checker (
	input wire clock,
	input wire reset,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire pready,
	input wire pslverr,
	input wire irq,
	input wire wakeup,
	input wire port_reset,
	input wire sof_pulse,
	input wire [1:0] control_bulk_ratio
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	wire ctrl_wr = psel && penable && pready && pwrite && paddr == 12'h004;
	wire [1:0] wr_ratio = pwdata[1:0];
	a_answer_next: assert property (psel && penable && !pready |=> pready)
		else $error("No answer");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("Ready too long");
	a_err_unmapped: assert property (pready && paddr == 12'h008 |-> pslverr)
		else $error("No slave error");
	a_reset_state: assert property ($fell(reset) |-> port_reset)
		else $error("Ports not in reset");
	a_ratio_copy: assert property (ctrl_wr |=> control_bulk_ratio == $past(wr_ratio))
		else $error("Ratio not copied");
	a_state_ports: assert property (ctrl_wr && pwdata[7:6] == 2'h0 |=> port_reset)
		else $error("Reset state ignored");
	a_oper_ports: assert property (ctrl_wr && pwdata[7:6] == 2'h2 |=> !port_reset)
		else $error("Operational state ignored");
	a_sof_single: assert property (sof_pulse |=> !sof_pulse)
		else $error("Frame pulse too long");
	c_sof: cover property (sof_pulse);
	c_wake: cover property (wakeup);
	c_irq: cover property (irq);
endmodule
bind usbhmc_top usbhmc_checker u_chk (.clock(clock), .reset(reset), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.pslverr(pslverr), .irq(irq), .wakeup(wakeup), .port_reset(port_reset),
	.sof_pulse(sof_pulse), .control_bulk_ratio(control_bulk_ratio));

//--- verif/testbench.sv
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
	$display("Error %0t got %h exp %h", $time, a, b); end end
module testbench;
	logic clock = 1'h0, reset = 1'h1, soft_reset = 1'h0, wake_req = 1'h0, err;
	logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, rd;
	wire resume_pin, pready, pslverr, irq, wakeup, port_reset, sof_pulse;
	wire ctrl_active, bulk_active, periodic_active, iso_active;
	wire [31:0] prdata;
	wire [1:0] control_bulk_ratio;
	int errors = 0, checked = 0, cycles = 0, n, i;
	always #25 clock = ~clock;
	usbhmc_top #(.SOF_DELAY_CYC(20), .FRAME_CYC(30)) u_usbhmc_top (.clock(clock),
		.reset(reset), .soft_reset(soft_reset), .resume_pin(resume_pin), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .wakeup(wakeup),
		.port_reset(port_reset), .sof_pulse(sof_pulse), .ctrl_active(ctrl_active),
		.bulk_active(bulk_active), .periodic_active(periodic_active),
		.iso_active(iso_active), .control_bulk_ratio(control_bulk_ratio));
	usbhmc_dev u_usbhmc_dev (.clock(clock), .wake_req(wake_req), .resume_pin(resume_pin));
	task summarize;
		$display("Checks %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			errors++;
			summarize;
		end
	end
	task apb(input [11:0] a, input w, input [31:0] d);
		@(posedge clock);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'h1;
		do @(posedge clock); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task wsof;
		do @(negedge clock); while (sof_pulse !== 1'h1);
		repeat (2) @(negedge clock);
	endtask
	initial begin
		repeat (5) @(posedge clock);
		reset <= 1'h0;
		apb(12'h004, 1'h0, 32'h0);
		`CHK(rd[10:0], 11'h000)
		`CHK(port_reset, 1'h1)
		apb(12'h004, 1'h1, 32'h000006ff);
		apb(12'h004, 1'h0, 32'h0);
		`CHK(rd[10:0], 11'h6ff)
		`CHK(control_bulk_ratio, 2'h3)
		for (i = 0; i < 6; i++) begin
			n = i < 4 ? i : 6 - i;
			apb(12'h004, 1'h1, n << 6);
			apb(12'h004, 1'h0, 32'h0);
			`CHK(rd[7:6], n[1:0])
			`CHK(port_reset, n == 0)
		end
		apb(12'h008, 1'h1, 32'hffffffff);
		`CHK(err, 1'h1)
		$display("Test registers done");
		apb(12'h010, 1'h1, 32'h4);
		apb(12'h004, 1'h1, 32'h000000bc);
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while (sof_pulse !== 1'h1);
		`CHK(n >= 19 && n <= 23, 1'h1)
		repeat (2) @(negedge clock);
		`CHK({ctrl_active, bulk_active, periodic_active, iso_active}, 4'hf)
		`CHK(irq, 1'h1)
		apb(12'h00c, 1'h1, 32'h4);
		apb(12'h00c, 1'h0, 32'h0);
		`CHK({rd[2], irq}, 2'h0)
		apb(12'h010, 1'h1, 32'h0);
		apb(12'h004, 1'h1, 32'h000000ac);
		`CHK(ctrl_active, 1'h1)
		wsof;
		`CHK({ctrl_active, bulk_active, irq}, 3'h2)
		apb(12'h004, 1'h1, 32'h000000bc);
		wsof;
		`CHK(ctrl_active, 1'h1)
		$display("Test frames done");
		apb(12'h004, 1'h1, 32'h000004c0);
		wake_req <= 1'h1;
		@(posedge clock);
		wake_req <= 1'h0;
		repeat (12) @(negedge clock);
		`CHK(wakeup, 1'h1)
		apb(12'h004, 1'h0, 32'h0);
		`CHK(rd[10:6], 5'h11)
		apb(12'h004, 1'h1, 32'h00000040);
		apb(12'h010, 1'h1, 32'h8);
		repeat (2) @(negedge clock);
		`CHK({wakeup, irq}, 2'h1)
		$display("Test resume done");
		apb(12'h004, 1'h1, 32'h00000200);
		soft_reset <= 1'h1;
		@(posedge clock);
		soft_reset <= 1'h0;
		apb(12'h004, 1'h0, 32'h0);
		`CHK(rd[10:0], 11'h2c0)
		reset <= 1'h1;
		repeat (5) @(posedge clock);
		reset <= 1'h0;
		apb(12'h004, 1'h0, 32'h0);
		`CHK({rd[10:0], port_reset}, 12'h001)
		$display("Test resets done");
		summarize;
	end
endmodule
